// *** logic/dacif_defs.svh ***
`ifndef DACIF_DEFS_SVH
`define DACIF_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DACIF_OFS_CONTROL_COMMAND 8'h00
`define DACIF_OFS_MODE_CONFIG 8'h04
`define DACIF_OFS_HOLDING_DATA 8'h08
`define DACIF_OFS_OUTPUT_DATA 8'h0C
`define DACIF_OFS_STATUS_FLAGS 8'h10
`define DACIF_OFS_IRQ_ENABLE_SET 8'h14
`define DACIF_OFS_IRQ_DISABLE_SET 8'h18
`define DACIF_OFS_IRQ_MASK_STATE 8'h1C
`define DACIF_OFS_EVENT_STATUS 8'h20
`define DACIF_OFS_EVENT_CLEAR 8'h24
`define DACIF_OFS_EVENT_ENABLE 8'h28

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DACIF_BIT_SOFT_RESET_CMD 0
`define DACIF_BIT_TIMER_TRIGGER_ENABLE 0
`define DACIF_LSB_TRIGGER_SOURCE_SELECT 1
`define DACIF_MSB_TRIGGER_SOURCE_SELECT 3
`define DACIF_BIT_RESOLUTION_SELECT 4
`define DACIF_BIT_TRANSFER_DONE_FLAG 0
`define DACIF_BIT_TRANSFER_EVENT 0
`define DACIF_DATA_MSB 9
`define DACIF_SHIFT_8BIT 2

// ----------------------------------------------------------------
// Reset values, counts and transfer size codes
// ----------------------------------------------------------------
`define DACIF_RST_MODE_CONFIG 5'h00
`define DACIF_RST_DATA 10'h000
`define DACIF_TRIGGER_SOURCES 6
`define DACIF_HSIZE_BYTE 3'h0
`define DACIF_HSIZE_HALF 3'h1

`endif

// *** logic/dacif_pkg.sv ***
package dacif_pkg;

    typedef struct packed {
        logic [4:0] mode;
        logic [9:0] holding;
        logic [9:0] out_data;
        logic pending;
        logic done_flag;
        logic irq_mask;
        logic evt_status;
        logic evt_enable;
        logic [5:0] sync1;
        logic [5:0] sync2;
        logic [5:0] sync3;
        logic [5:0] stable;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [2:0] ap_size;
        logic rd_wait;
        logic [31:0] rdata;
    } dacif_state_type;

endpackage

// *** logic/dacif_top.sv ***
// Functional notes
// - Mode bit 4 picks 10-bit operation when 0 and 8-bit operation when 1.
// - In 8-bit mode a holding write is stored shifted left by two with zero low bits.
// - DMA transfers are single bytes in 8-bit mode and half-words in 10-bit mode.
// - With timer triggering off, a holding write reaches the output one cycle later.
// - With timer triggering on, each rising edge of the chosen timer wave copies holding.
// - Mode bits 3..1 choose timer wave 0..5, values 6 and 7 choose none.
// - Status bit 0 is 0 while data waits, 1 once moved, 0 with triggering off or at reset.
// - Writing 1 to enable bit 0 turns the transfer-done interrupt on, 0 does nothing.
// - Writing 1 to disable bit 0 turns the transfer-done interrupt off, 0 does nothing.
// - Mask bit 0 reads 1 while the transfer-done interrupt is enabled.
// - Writing 1 to control bit 0 resets the converter logic, 0 does nothing.
// - Holding data reads back right-aligned in bits 9..0 after adjustment, others zero.
// - Output data reads the value under conversion, right-aligned, others zero.
// - Output data ignores bus writes and changes only by transfers from holding or by a soft reset.
`timescale 1ns/1ns
`include "dacif_defs.svh"

module dacif_top #(
    parameter int TRIGGER_SOURCES = `DACIF_TRIGGER_SOURCES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [TRIGGER_SOURCES-1:0] timer_wave_output,
    output logic [9:0] dac_value,
    output logic [2:0] dma_xfer_size,
    output logic irq
);

    dacif_pkg::dacif_state_type r_q;
    dacif_pkg::dacif_state_type r_d;

    logic wr_en;
    logic [9:0] wr_value;
    logic [2:0] trig_sel;
    logic trig_on;
    logic [5:0] wave_rise;
    logic trig_edge;
    logic [31:0] rd_mux;

    // ----------------------------------------------------------------
    // Read data selection
    // ----------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (r_q.ap_addr)
            `DACIF_OFS_MODE_CONFIG: begin
                rd_mux[4:0] = r_q.mode;
            end
            `DACIF_OFS_HOLDING_DATA: begin
                rd_mux[9:0] = r_q.holding;
            end
            `DACIF_OFS_OUTPUT_DATA: begin
                rd_mux[9:0] = r_q.out_data;
            end
            `DACIF_OFS_STATUS_FLAGS: begin
                rd_mux[`DACIF_BIT_TRANSFER_DONE_FLAG] = r_q.done_flag;
            end
            `DACIF_OFS_IRQ_MASK_STATE: begin
                rd_mux[`DACIF_BIT_TRANSFER_DONE_FLAG] = r_q.irq_mask;
            end
            `DACIF_OFS_EVENT_STATUS: begin
                rd_mux[`DACIF_BIT_TRANSFER_EVENT] = r_q.evt_status;
            end
            `DACIF_OFS_EVENT_ENABLE: begin
                rd_mux[`DACIF_BIT_TRANSFER_EVENT] = r_q.evt_enable;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Trigger selection
    // ----------------------------------------------------------------
    always_comb begin
        trig_sel = r_q.mode[`DACIF_MSB_TRIGGER_SOURCE_SELECT:`DACIF_LSB_TRIGGER_SOURCE_SELECT];
        trig_on = r_q.mode[`DACIF_BIT_TIMER_TRIGGER_ENABLE];
        // A rise counts once the second and third stages agree high
        wave_rise = 6'h00;
        wave_rise[TRIGGER_SOURCES-1:0] = r_q.sync2[TRIGGER_SOURCES-1:0]
            & r_q.sync3[TRIGGER_SOURCES-1:0] & ~r_q.stable[TRIGGER_SOURCES-1:0];
        trig_edge = 1'b0;
        if (trig_on && ({1'b0, trig_sel} < 4'(TRIGGER_SOURCES))) begin
            trig_edge = wave_rise[trig_sel];
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        wr_en = r_q.ap_valid && r_q.ap_write;
        wr_value = `DACIF_RST_DATA;

        // Timer wave synchroniser
        r_d.sync1 = 6'h00;
        r_d.sync1[TRIGGER_SOURCES-1:0] = timer_wave_output;
        r_d.sync2 = r_q.sync1;
        r_d.sync3 = r_q.sync2;
        for (int i = 0; i < 6; i++) begin
            if (r_q.sync2[i] == r_q.sync3[i]) begin
                r_d.stable[i] = r_q.sync3[i];
            end
        end

        // Bus address phase
        if (hready) begin
            r_d.ap_valid = hsel && htrans[1];
            r_d.ap_write = hwrite;
            r_d.ap_addr = haddr[7:0];
            r_d.ap_size = hsize;
            r_d.rd_wait = hsel && htrans[1] && !hwrite;
        end else begin
            r_d.ap_valid = 1'b0;
            r_d.rd_wait = 1'b0;
        end

        // Reads take one wait state so prior writes are visible
        if (r_q.rd_wait) begin
            r_d.rdata = rd_mux;
        end

        // Transfer from holding to output
        if (!trig_on && r_q.pending) begin
            r_d.out_data = r_q.holding;
            r_d.pending = 1'b0;
            r_d.evt_status = 1'b1;
        end
        if (trig_edge) begin
            r_d.out_data = r_q.holding;
            r_d.pending = 1'b0;
            r_d.done_flag = 1'b1;
            r_d.evt_status = 1'b1;
        end

        // Register writes
        if (wr_en) begin
            case (r_q.ap_addr)
                `DACIF_OFS_CONTROL_COMMAND: begin
                    if (hwdata[`DACIF_BIT_SOFT_RESET_CMD]) begin
                        r_d.mode = `DACIF_RST_MODE_CONFIG;
                        r_d.holding = `DACIF_RST_DATA;
                        r_d.out_data = `DACIF_RST_DATA;
                        r_d.pending = 1'b0;
                        r_d.done_flag = 1'b0;
                        r_d.irq_mask = 1'b0;
                        r_d.evt_status = 1'b0;
                        r_d.evt_enable = 1'b0;
                    end
                end
                `DACIF_OFS_MODE_CONFIG: begin
                    r_d.mode = hwdata[4:0];
                    if (!hwdata[`DACIF_BIT_TIMER_TRIGGER_ENABLE]) begin
                        r_d.done_flag = 1'b0;
                    end else if (!trig_on) begin
                        r_d.done_flag = 1'b1;
                        r_d.pending = 1'b0;
                    end
                end
                `DACIF_OFS_HOLDING_DATA: begin
                    // Byte writes carry 8 data bits, wider writes 10
                    if (r_q.ap_size == `DACIF_HSIZE_BYTE) begin
                        wr_value = {2'b00, hwdata[7:0]};
                    end else begin
                        wr_value = hwdata[9:0];
                    end
                    if (r_q.mode[`DACIF_BIT_RESOLUTION_SELECT]) begin
                        r_d.holding = {wr_value[7:0], 2'b00};
                    end else begin
                        r_d.holding = wr_value;
                    end
                    r_d.pending = 1'b1;
                    if (trig_on) begin
                        r_d.done_flag = 1'b0;
                    end
                end
                `DACIF_OFS_IRQ_ENABLE_SET: begin
                    if (hwdata[`DACIF_BIT_TRANSFER_DONE_FLAG]) begin
                        r_d.irq_mask = 1'b1;
                    end
                end
                `DACIF_OFS_IRQ_DISABLE_SET: begin
                    if (hwdata[`DACIF_BIT_TRANSFER_DONE_FLAG]) begin
                        r_d.irq_mask = 1'b0;
                    end
                end
                `DACIF_OFS_EVENT_CLEAR: begin
                    // A transfer in the same cycle keeps the event set
                    if (hwdata[`DACIF_BIT_TRANSFER_EVENT] && !r_d.evt_status) begin
                        r_d.evt_status = 1'b0;
                    end else if (hwdata[`DACIF_BIT_TRANSFER_EVENT]) begin
                        r_d.evt_status = (!trig_on && r_q.pending) || trig_edge;
                    end
                end
                `DACIF_OFS_EVENT_ENABLE: begin
                    r_d.evt_enable = hwdata[`DACIF_BIT_TRANSFER_EVENT];
                end
                default: begin
                    r_d.rd_wait = r_d.rd_wait;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_comb begin
        hreadyout = !r_q.rd_wait;
        hresp = 1'b0;
        hrdata = r_q.rdata;
        dac_value = r_q.out_data;
        if (r_q.mode[`DACIF_BIT_RESOLUTION_SELECT]) begin
            dma_xfer_size = `DACIF_HSIZE_BYTE;
        end else begin
            dma_xfer_size = `DACIF_HSIZE_HALF;
        end
        irq = (r_q.done_flag && r_q.irq_mask) || (r_q.evt_status && r_q.evt_enable);
    end

endmodule

// *** verification/dacif_top_props.sv ***
`timescale 1ns/1ns
module dacif_top_props #(
    parameter int TRIGGER_SOURCES = 6
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [9:0] dac_value,
    input wire logic [2:0] dma_xfer_size,
    input wire logic irq
);
    // ------------------------------------------------------------
    // Shadow of bus writes
    // ------------------------------------------------------------
    logic ap_wr_q;
    logic [7:0] ap_addr_q;
    logic [4:0] mode_q;
    logic [9:0] exp_q;
    logic dp_wr;
    assign dp_wr = ap_wr_q && hready;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ap_wr_q <= 1'b0;
            mode_q <= 5'h00;
        end else begin
            if (hready) begin
                ap_wr_q <= hsel && htrans[1] && hwrite;
                ap_addr_q <= haddr[7:0];
            end
            if (dp_wr && ap_addr_q == 8'h04) begin
                mode_q <= hwdata[4:0];
            end
            if (dp_wr && ap_addr_q == 8'h00 && hwdata[0]) begin
                mode_q <= 5'h00;
            end
            if (dp_wr && ap_addr_q == 8'h08) begin
                exp_q <= mode_q[4] ? {hwdata[7:0], 2'h0} : hwdata[9:0];
            end
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    chk_read_wait: assert property (
        hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait state");
    chk_write_no_wait: assert property (
        hsel && hready && htrans[1] && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    chk_reset_clean: assert property (
        $rose(rst_b) |-> dac_value == 10'h000 && !irq && dma_xfer_size == 3'h1)
        else $error("outputs not cleared by reset");
    chk_direct_copy: assert property (
        dp_wr && ap_addr_q == 8'h08 && !mode_q[0] |=> ##1 dac_value == exp_q)
        else $error("holding value not copied one cycle later");
    chk_dma_size: assert property (
        dma_xfer_size == (mode_q[4] ? 3'h0 : 3'h1))
        else $error("transfer size does not follow resolution");
    chk_output_ro: assert property (
        dp_wr && ap_addr_q == 8'h0C |=> $stable(dac_value))
        else $error("output register took a bus write");
    chk_reserved_sel: assert property (
        (mode_q[0] && mode_q[3:1] > 3'h5 && !(dp_wr && ap_addr_q == 8'h00)) [*6]
        |=> $stable(dac_value))
        else $error("reserved trigger source moved data");
    cover property (dp_wr && ap_addr_q == 8'h08 && mode_q[0]);
    cover property ($changed(dac_value) && mode_q[0]);
    cover property ($rose(irq));
endmodule

bind dacif_top dacif_top_props #(.TRIGGER_SOURCES(TRIGGER_SOURCES)) dacif_top_props_i (
    .clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hresp, .dac_value, .dma_xfer_size, .irq
);

// *** verification/dacif_timer_model.sv ***
`timescale 1ns/1ns
module dacif_timer_model (
    input wire logic clk,
    input wire logic [5:0] fire,
    input wire logic slow,
    output logic [5:0] wave
);
    // Waveform-mode outputs: one high pulse per request, short or long
    always @(posedge clk) begin
        if (fire != 6'h00) begin
            wave <= fire;
            repeat (slow ? 5 : 2) @(posedge clk);
            wave <= 6'h00;
        end else begin
            wave <= 6'h00;
        end
    end
endmodule

// *** verification/dacif_top_tb.sv ***
`timescale 1ns/1ns
module dacif_top_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [2:0] sz = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, irq;
    logic [31:0] hrdata, rd_q;
    logic [31:0] prev = 32'h2AC;
    logic [9:0] dac_value;
    logic [2:0] dma_xfer_size;
    logic [5:0] wave;
    logic [5:0] fire = 6'h00;
    logic slow = 1'b0;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    always #2 clk = ~clk;
    dacif_top dacif_top_i (
        .clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .timer_wave_output(wave), .dac_value, .dma_xfer_size, .irq
    );
    dacif_timer_model dacif_timer_model_i (.clk, .fire, .slow, .wave);
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        hsize <= sz;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd_q = hrdata;
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, rd_q, e);
    endtask
    task automatic pulse(input logic [5:0] m);
        fire <= m;
        @(posedge clk);
        fire <= 6'h00;
        repeat (12) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int a = 4; a <= 16; a += 4) rc("reset", 8'(a), 32'h0);
        rc("mask reset", 8'h1C, 32'h0);
        rc("unmapped", 8'h40, 32'h0);
        bus(1'b1, 8'h08, 32'hFFFF_F3A5);
        rc("hold", 8'h08, 32'h3A5);
        rc("out", 8'h0C, 32'h3A5);
        rc("done off", 8'h10, 32'h0);
        bus(1'b1, 8'h0C, 32'h155);
        rc("out ro", 8'h0C, 32'h3A5);
        bus(1'b1, 8'h04, 32'h10);
        @(posedge clk);
        chk("size", {29'h0, dma_xfer_size}, 32'h0);
        sz = 3'h0;
        bus(1'b1, 8'h08, 32'h1AB);
        sz = 3'h2;
        rc("hold8", 8'h08, 32'h2AC);
        rc("out8", 8'h0C, 32'h2AC);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, i < 2 ? 8'h14 : 8'h18, {31'h0, i[0]});
            rc("mask", 8'h1C, {31'h0, i == 1 || i == 2});
        end
        bus(1'b1, 8'h14, 32'h1);
        for (int c = 0; c < 7; c++) begin
            bus(1'b1, 8'h04, {28'h0, 3'(c), 1'b1});
            rc("armed", 8'h10, 32'h1);
            bus(1'b1, 8'h08, 32'(c * 37 + 64));
            rc("waiting", 8'h10, 32'h0);
            chk("irq low", {31'h0, irq}, 32'h0);
            slow <= c[0];
            pulse(~(6'h01 << c));
            rc("other", 8'h0C, prev);
            pulse(6'h01 << c);
            if (c < 6) prev = 32'(c * 37 + 64);
            rc("trig", 8'h0C, prev);
            rc("done", 8'h10, {31'h0, c < 6});
            chk("irq", {31'h0, irq}, {31'h0, c < 6});
        end
        bus(1'b1, 8'h18, 32'h1);
        @(posedge clk);
        chk("irq off", {31'h0, irq}, 32'h0);
        bus(1'b1, 8'h28, 32'h1);
        rc("event", 8'h20, 32'h1);
        chk("irq event", {31'h0, irq}, 32'h1);
        bus(1'b1, 8'h24, 32'h1);
        rc("event clr", 8'h20, 32'h0);
        chk("irq clr", {31'h0, irq}, 32'h0);
        bus(1'b1, 8'h00, 32'h0);
        rc("mode kept", 8'h04, 32'h0D);
        bus(1'b1, 8'h00, 32'h1);
        rc("mode clr", 8'h04, 32'h0);
        rc("out clr", 8'h0C, 32'h0);
        close_out();
    end
endmodule
